// *** fdc_ctrl_defs.svh ***
`ifndef FDC_CTRL_DEFS_SVH
`define FDC_CTRL_DEFS_SVH

// Host register addresses.
`define ADDR_OUTP       10'h002
`define ADDR_STAT_RSEL  10'h004
`define ADDR_DATA       10'h005
`define ADDR_RSEL_RB    10'h008
`define ADDR_COMPAT     10'h3F7

// Field positions.
`define RSEL_RST_BIT    7
`define RSEL_LP_BIT     6
`define RSEL_PRE_LSB    2
`define OUTP_RST_BIT    2

// Reset values.
`define RSEL_RST_VAL    7'h00
`define OUTP_RST_VAL    8'h00
`define RATE_RST_VAL    2'h0
`define STAT_BUSY       8'h00

// Data rate encodings.
`define RATE_500K       2'h0
`define RATE_300K       2'h1
`define RATE_250K       2'h2
`define RATE_1M         2'h3

// Pre-erase lead (38 and 19 bytes) and ID-to-data gap (22 and 41 bytes).
`define PREERASE_1M     8'h26
`define PREERASE_500K   8'h13
`define IDGAP_STD       8'h16
`define IDGAP_PERP      8'h29

// Timing.
`define CLK_PERIOD_NS   50
`define INIT_SETTLE_NS  1000
`define INIT_LIMIT_NS   2500
`define AUTO_LP_MS      500
`define OSC_STABLE_MS   2
`define BIT_NS_500K     2000
`define BIT_NS_300K     3333
`define BIT_NS_250K     4000
`define BIT_NS_1M       1000

`endif

// *** fdc_ctrl_pkg.sv ***
package fdc_ctrl_pkg;

   typedef enum {
      PWR_INIT,
      PWR_RUN,
      PWR_LOW,
      PWR_WAKE
   } pwr_state_t;

   // Parameters set by the configure, lock, mode and perpendicular commands.
   typedef struct packed {
      logic       perpMode;
      logic       lockParams;
      logic       fifoEnable;
      logic [3:0] fifoThreshold;
      logic [7:0] precompStartTrack;
      logic       impliedSeek;
      logic       pollEnable;
      logic       fifoWriteSel;
      logic       fifoReadSel;
      logic       burstSel;
      logic       autoLpEn;
      logic       manualLp;
      logic       oscPowerdownCfg;
   } cfg_t;

   // Write context from the disk sequencer.
   typedef struct packed {
      logic       writeOp;
      logic       formatOp;
      logic [7:0] bytesToPreamble;
   } wr_ctx_t;

endpackage

// *** fdc_rate_divider.sv ***
module fdc_rate_divider #(
   parameter int CNT_W = 8
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             arst_n,
   // Control
   input  wire logic             run,
   input  wire logic [CNT_W-1:0] period,
   // Enable pulse
   output logic                  tick
);

   logic [CNT_W-1:0] cnt_r;

   // Reloading on each tick lets a new rate take hold at the next bit cell.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else if (!run) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else if (cnt_r == '0) begin
         cnt_r <= period - CNT_W'(1);
         tick  <= 1'b1;
      end else begin
         cnt_r <= cnt_r - CNT_W'(1);
         tick  <= 1'b0;
      end
   end

endmodule // fdc_rate_divider

// *** floppy_drive_model.sv ***
module floppy_drive_model
   import fdc_ctrl_pkg::*;
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       arst_n,
   // Bench control: 0 idle, 1 write, 2 format, 3 read
   input  wire logic [1:0] op,
   // Controller side
   input  wire logic       bitTick,
   input  wire logic       write_gate,
   output wr_ctx_t         wrCtx,
   // Observation
   output logic      [7:0] gateAt,
   output logic            gateSeen,
   output logic            done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] prevB;
   // The head closes on the preamble one unit per rate tick, so the gate lead shows as the count left.
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n || op == 2'h0) begin
         wrCtx    <= '{1'b0, 1'b0, 8'h28};
         gateSeen <= 1'b0;
         gateAt   <= 8'hFF;
      end else begin
         wrCtx.writeOp  <= (op == 2'h1);
         wrCtx.formatOp <= (op == 2'h2);
         if (bitTick && wrCtx.bytesToPreamble != 8'h00) begin
            wrCtx.bytesToPreamble <= wrCtx.bytesToPreamble - 8'h01;
         end
         if (write_gate && !gateSeen) begin
            gateSeen <= 1'b1;
            gateAt   <= prevB;
         end
      end
      prevB <= wrCtx.bytesToPreamble;
   end
   assign done = (wrCtx.bytesToPreamble == 8'h00);
endmodule // floppy_drive_model

// *** floppy_rate_power_reset_ctrl.sv ***
// Functional notes
// - Perpendicular writes raise write gate 38 bytes early at 1M, 19 at 500k.
// - Perpendicular format at 1M uses a 41 byte ID gap, otherwise 22.
// - Early write gate only for format and write data, never for reads.
// - Perpendicular mode adapts write parameters at 1M and 500k only; 300k and 250k get no lead.
// - Rate comes from the low two bits of the compatible rate register.
// - Rate select register low two bits set rate with the same encoding.
// - Last written rate wins; clocks and rate pins follow it.
// - Precompensation defaults at power-up; start track zero; both reprogrammable.
// - Low power always gates the controller clock; oscillator stops if configured.
// - Entering power-down clears the host-may-transfer flag.
// - Rate select bit 6 enters low power at once; reads 0 after exit.
// - Manual low power request is the OR of register bit and mode setting.
// - Auto low power enters power-down after the idle time, every idle entry.
// - Soft reset or data/status access wakes; access keeps all settings.
// - After wake, transfer flag stays 0 until the oscillator is stable.
// - Rate select, output and compatible rate registers survive power-down.
// - Hardware reset restores defaults: FIFO off, threshold 0, seeks off, polling on.
// - Rate select reset bit clears itself; output register reset bit holds.
// - With lock set, soft reset keeps FIFO, threshold, track, and mode FIFO/burst bits.
// - Status reads 00h after reset, then 80h within 2.5 us.
`include "fdc_ctrl_defs.svh"

module floppy_rate_power_reset_ctrl
   import fdc_ctrl_pkg::*;
#(
   parameter int AUTO_LP_CYCLES = (`AUTO_LP_MS * 1000000) / `CLK_PERIOD_NS,
   parameter int OSC_CYCLES     = (`OSC_STABLE_MS * 1000000) / `CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       arst_n,
   // Host register port
   input  wire logic [9:0] hostAddr,
   input  wire logic       hostWrEn,
   input  wire logic       hostRdEn,
   input  wire logic [7:0] hostWData,
   output logic      [7:0] hostRData,
   // Command engine
   input  wire logic       cmdIdle,
   input  wire logic       cmdRqm,
   input  wire logic [6:0] cmdStatus,
   input  wire logic [7:0] dataRdIn,
   input  wire logic       cfgLoad,
   input  wire cfg_t       cfgIn,
   output cfg_t            cfgOut,
   output logic            dataWrStb,
   output logic            dataRdStb,
   output logic      [7:0] dataWrByte,
   output logic            ctrlReset,
   // Drive side
   input  wire wr_ctx_t    wrCtx,
   output logic            write_gate,
   output logic      [7:0] id_data_gap,
   output logic            rate_out_bit0,
   output logic            rate_out_bit1,
   output logic      [2:0] precompSel,
   output logic      [7:0] driveCtl,
   // Power and timing
   output logic            ctrlClkEn,
   output logic            oscStop,
   output logic            bitTick
);

   localparam int INIT_CYCLES = (`INIT_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam int INIT_MAX    = `INIT_LIMIT_NS / `CLK_PERIOD_NS;
   localparam int AUTO_W      = $clog2(AUTO_LP_CYCLES + 1);
   localparam int WAIT_W      = $clog2(OSC_CYCLES + INIT_CYCLES + 1);
   localparam int DIV_W       = 8;

   pwr_state_t        state_r, state_nxt;
   logic [6:0]        rsel_r;
   logic [7:0]        outp_r;
   logic [1:0]        rate_r;
   cfg_t              cfg_r;
   logic [WAIT_W-1:0] waitCnt_r;
   logic [AUTO_W-1:0] autoCnt_r;
   logic              lpReqPrev_r;
   logic              write_gate_r;
   logic [7:0]        statVal;
   logic [7:0]        leadBytes;
   logic [DIV_W-1:0]  divPeriod;
   logic              rselWrite, compatWrite, outpWrite, dataAcc, statRead;
   logic              softRst, lpReq, lpEnter, autoExpire, wakeAcc;

   // Address decode.
   always_comb begin
      rselWrite   = 1'b0;
      compatWrite = 1'b0;
      outpWrite   = 1'b0;
      statRead    = 1'b0;
      dataAcc     = 1'b0;
      if (hostAddr == `ADDR_STAT_RSEL) begin
         rselWrite = hostWrEn;
         statRead  = hostRdEn;
      end else if (hostAddr == `ADDR_COMPAT) begin
         compatWrite = hostWrEn;
      end else if (hostAddr == `ADDR_OUTP) begin
         outpWrite = hostWrEn;
      end else if (hostAddr == `ADDR_DATA) begin
         dataAcc   = hostWrEn | hostRdEn;
      end
   end

   // The rate select reset acts for one write only; the output register bit holds.
   assign softRst    = (rselWrite & hostWData[`RSEL_RST_BIT]) | outp_r[`OUTP_RST_BIT];
   assign lpReq      = rsel_r[`RSEL_LP_BIT] | cfg_r.manualLp;
   // Entry on the rising request avoids falling straight back asleep after a wake.
   assign lpEnter    = (lpReq & ~lpReqPrev_r) | autoExpire;
   assign autoExpire = cfg_r.autoLpEn && cmdIdle && (autoCnt_r == AUTO_W'(AUTO_LP_CYCLES - 1));
   assign wakeAcc    = dataAcc | statRead;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         PWR_INIT: if (waitCnt_r == WAIT_W'(INIT_CYCLES - 1)) state_nxt = PWR_RUN;
         PWR_RUN:  if (lpEnter) state_nxt = PWR_LOW;
         PWR_LOW:  if (wakeAcc) state_nxt = PWR_WAKE;
         PWR_WAKE: if (waitCnt_r == WAIT_W'(OSC_CYCLES - 1) || !cfg_r.oscPowerdownCfg) state_nxt = PWR_RUN;
         default:  state_nxt = PWR_INIT;
      endcase
      if (softRst) state_nxt = PWR_INIT;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) state_r <= PWR_INIT;
      else         state_r <= state_nxt;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)                                  waitCnt_r <= '0;
      else if (state_nxt != state_r || softRst)     waitCnt_r <= '0;
      else if (state_r == PWR_INIT || state_r == PWR_WAKE) waitCnt_r <= waitCnt_r + WAIT_W'(1);
   end

   // The idle time is counted on the reference clock, so it does not scale with rate.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)                                                 autoCnt_r <= '0;
      else if (state_r != PWR_RUN || !cmdIdle || !cfg_r.autoLpEn || autoExpire) autoCnt_r <= '0;
      else                                                         autoCnt_r <= autoCnt_r + AUTO_W'(1);
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) lpReqPrev_r <= 1'b0;
      else         lpReqPrev_r <= lpReq;
   end

   // Rate select register; leaving power-down clears only the low power bit.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rsel_r <= `RSEL_RST_VAL;
      end else if (rselWrite) begin
         rsel_r <= hostWData[6:0];
      end else if (state_r == PWR_LOW && state_nxt != PWR_LOW) begin
         rsel_r[`RSEL_LP_BIT] <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)        outp_r <= `OUTP_RST_VAL;
      else if (outpWrite) outp_r <= hostWData;
   end

   // Whichever rate register was written last sets the rate.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n)          rate_r <= `RATE_RST_VAL;
      else if (compatWrite) rate_r <= hostWData[1:0];
      else if (rselWrite)   rate_r <= hostWData[1:0];
   end

   // Command parameters, with lock retention across soft reset.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_r            <= '0;
         cfg_r.pollEnable <= 1'b1;
      end else if (cfgLoad) begin
         cfg_r <= cfgIn;
      end else if (softRst) begin
         cfg_r            <= '0;
         cfg_r.pollEnable <= 1'b1;
         cfg_r.lockParams <= cfg_r.lockParams;
         if (cfg_r.lockParams) begin
            cfg_r.fifoEnable        <= cfg_r.fifoEnable;
            cfg_r.fifoThreshold     <= cfg_r.fifoThreshold;
            cfg_r.precompStartTrack <= cfg_r.precompStartTrack;
            cfg_r.fifoWriteSel      <= cfg_r.fifoWriteSel;
            cfg_r.fifoReadSel       <= cfg_r.fifoReadSel;
            cfg_r.burstSel          <= cfg_r.burstSel;
         end
      end
   end

   // Status shows 00h outside normal running, which also holds the transfer flag low.
   assign statVal = (state_r == PWR_RUN) ? {cmdRqm, cmdStatus} : `STAT_BUSY;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         hostRData <= 8'h00;
      end else if (hostRdEn) begin
         if (hostAddr == `ADDR_STAT_RSEL)    hostRData <= statVal;
         else if (hostAddr == `ADDR_DATA)    hostRData <= (state_r == PWR_RUN) ? dataRdIn : 8'h00;
         else if (hostAddr == `ADDR_RSEL_RB) hostRData <= {1'b0, rsel_r};
         else if (hostAddr == `ADDR_OUTP)    hostRData <= outp_r;
         else                               hostRData <= 8'h00;
      end
   end

   // A data access that only wakes the controller is not passed on.
   assign dataWrStb  = hostWrEn && hostAddr == `ADDR_DATA && state_r == PWR_RUN;
   assign dataRdStb  = hostRdEn && hostAddr == `ADDR_DATA && state_r == PWR_RUN;
   assign dataWrByte = hostWData;
   assign ctrlReset  = (state_r == PWR_INIT);
   assign cfgOut     = cfg_r;

   assign ctrlClkEn  = (state_r != PWR_LOW);
   assign oscStop    = (state_r == PWR_LOW) && cfg_r.oscPowerdownCfg;

   // Pre-erase lead depends on rate; reads and conventional drives get none.
   always_comb begin
      leadBytes = 8'h00;
      if (cfg_r.perpMode && (wrCtx.writeOp || wrCtx.formatOp)) begin
         if (rate_r == `RATE_1M)        leadBytes = `PREERASE_1M;
         else if (rate_r == `RATE_500K) leadBytes = `PREERASE_500K;
      end
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) write_gate_r <= 1'b0;
      else write_gate_r <= (wrCtx.writeOp || wrCtx.formatOp) && state_r == PWR_RUN
                           && wrCtx.bytesToPreamble <= leadBytes;
   end
   assign write_gate = write_gate_r;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) id_data_gap <= `IDGAP_STD;
      else if (cfg_r.perpMode && rate_r == `RATE_1M) id_data_gap <= `IDGAP_PERP;
      else id_data_gap <= `IDGAP_STD;
   end

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rate_out_bit0 <= 1'b0;
         rate_out_bit1 <= 1'b0;
         precompSel    <= 3'h0;
         driveCtl      <= 8'h00;
      end else begin
         rate_out_bit0 <= rate_r[0];
         rate_out_bit1 <= rate_r[1];
         precompSel    <= rsel_r[`RSEL_PRE_LSB +: 3];
         driveCtl      <= outp_r;
      end
   end

   // Bit-cell enable scales with the selected rate.
   always_comb begin
      case (rate_r)
         `RATE_300K: divPeriod = DIV_W'(`BIT_NS_300K / `CLK_PERIOD_NS);
         `RATE_250K: divPeriod = DIV_W'(`BIT_NS_250K / `CLK_PERIOD_NS);
         `RATE_1M:   divPeriod = DIV_W'(`BIT_NS_1M / `CLK_PERIOD_NS);
         default:    divPeriod = DIV_W'(`BIT_NS_500K / `CLK_PERIOD_NS);
      endcase
   end

   fdc_rate_divider #(.CNT_W(DIV_W)) rateDiv (
      .mclk   (mclk),
      .arst_n (arst_n),
      .run    (ctrlClkEn),
      .period (divPeriod),
      .tick   (bitTick)
   );

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence s_leave_low;
      state_r == PWR_LOW ##1 (state_r != PWR_LOW && !$past(rselWrite));
   endsequence

   a_lp_rqm_clear: assert property (state_r == PWR_LOW |-> statVal[7] == 1'b0)
      else $error("transfer flag set in power-down");
   a_lp_clk_gate: assert property (state_r == PWR_LOW |-> !ctrlClkEn && oscStop == cfg_r.oscPowerdownCfg)
      else $error("clock gating wrong in power-down");
   a_rsel_lp_enter: assert property ((state_r == PWR_RUN && rselWrite && hostWData[6] && !hostWData[7]
                                      && !lpReq && !outp_r[2]) |=> ##1 state_r == PWR_LOW)
      else $error("low power bit did not enter power-down");
   a_lp_bit_clear: assert property (s_leave_low |-> !rsel_r[`RSEL_LP_BIT])
      else $error("low power bit still set after exit");
   a_wake_hold: assert property ((state_r == PWR_LOW && wakeAcc && !softRst) |=>
                                 state_r == PWR_WAKE && statVal == 8'h00)
      else $error("wake did not hold status at zero");
   a_init_bound: assert property (@(posedge mclk) disable iff (!arst_n || softRst)
                                  (state_r == PWR_INIT) |-> ##[0:INIT_MAX] statVal[7] || state_r == PWR_RUN)
      else $error("status not ready within limit after reset");
   a_init_zero: assert property (state_r == PWR_INIT |-> statVal == 8'h00)
      else $error("status not zero during initialisation");
   a_rate_pins: assert property ((compatWrite || rselWrite) |-> ##2 {rate_out_bit1, rate_out_bit0} == $past(hostWData[1:0], 2))
      else $error("rate pins do not follow last write");
   a_outp_hold: assert property (outp_r[`OUTP_RST_BIT] |=> state_r == PWR_INIT)
      else $error("held reset bit not keeping controller in reset");
   a_lock_keep: assert property ((softRst && cfg_r.lockParams && !cfgLoad) |=>
                                 cfg_r.fifoThreshold == $past(cfg_r.fifoThreshold)
                                 && cfg_r.precompStartTrack == $past(cfg_r.precompStartTrack)
                                 && cfg_r.burstSel == $past(cfg_r.burstSel))
      else $error("locked parameters lost on soft reset");
   a_auto_lp: assert property ((state_r == PWR_RUN && autoExpire && !softRst) |=> state_r == PWR_LOW)
      else $error("auto low power did not enter power-down");
   a_lead_1m: assert property ((state_r == PWR_RUN && cfg_r.perpMode && rate_r == `RATE_1M && wrCtx.writeOp
                                && wrCtx.bytesToPreamble == 8'h26) |=> write_gate)
      else $error("early write gate missing at 1M");
   a_read_no_gate: assert property (!(wrCtx.writeOp || wrCtx.formatOp) |=> !write_gate)
      else $error("write gate raised outside a write");
   a_gap_perp: assert property ((cfg_r.perpMode && rate_r == `RATE_1M) |=> id_data_gap == 8'h29)
      else $error("perpendicular gap wrong");

endmodule // floppy_rate_power_reset_ctrl

// *** floppy_rate_power_reset_ctrl_test.sv ***
`include "fdc_ctrl_defs.svh"
module floppy_rate_power_reset_ctrl_test
   import fdc_ctrl_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, arst_n, hostWrEn, hostRdEn, cmdIdle, cfgLoad, write_gate, rate_out_bit0, rate_out_bit1;
   logic ctrlClkEn, oscStop, bitTick, ctrlReset, gateSeen, done;
   logic [9:0] hostAddr;
   logic [7:0] hostWData, hostRData, dataRdIn, id_data_gap, gateAt, v, driveCtl;
   logic [2:0] precompSel, pc;
   logic [1:0] op, r;
   cfg_t       cfgIn, cfgOut, cfg, d, e;
   wr_ctx_t    wrCtx;
   int         n_mismatch, samples_checked, n, t0, cycles;

   floppy_rate_power_reset_ctrl #(.AUTO_LP_CYCLES(50), .OSC_CYCLES(10)) dut (
      .mclk(mclk), .arst_n(arst_n), .hostAddr(hostAddr), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
      .hostWData(hostWData), .hostRData(hostRData), .cmdIdle(cmdIdle), .cmdRqm(1'b1),
      .cmdStatus(7'h00), .dataRdIn(dataRdIn), .cfgLoad(cfgLoad), .cfgIn(cfgIn), .cfgOut(cfgOut),
      .dataWrStb(), .dataRdStb(), .dataWrByte(), .ctrlReset(ctrlReset), .wrCtx(wrCtx),
      .write_gate(write_gate), .id_data_gap(id_data_gap), .rate_out_bit0(rate_out_bit0),
      .rate_out_bit1(rate_out_bit1), .precompSel(precompSel), .driveCtl(driveCtl), .ctrlClkEn(ctrlClkEn),
      .oscStop(oscStop), .bitTick(bitTick));
   floppy_drive_model drive (.mclk(mclk), .arst_n(arst_n), .op(op), .bitTick(bitTick),
      .write_gate(write_gate), .wrCtx(wrCtx), .gateAt(gateAt), .gateSeen(gateSeen), .done(done));

   always #25 mclk = ~mclk;
   always @(posedge mclk) cycles++;

   task automatic finish_test;
      if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] x);
      @(negedge mclk);
      hostAddr  = a;
      hostWData = x;
      hostWrEn  = 1'b1;
      @(negedge mclk);
      hostWrEn = 1'b0;
   endtask
   task automatic rd(input logic [9:0] a, output logic [7:0] x);
      @(negedge mclk);
      hostAddr = a;
      hostRdEn = 1'b1;
      @(negedge mclk);
      hostRdEn = 1'b0;
      x = hostRData;
   endtask
   task automatic load(input cfg_t c);
      @(negedge mclk);
      cfgIn   = c;
      cfgLoad = 1'b1;
      @(negedge mclk);
      cfgLoad = 1'b0;
   endtask
   // Polls the status port like software would; a bound that runs out ends the run.
   task automatic statReady(input int lim);
      logic [7:0] s;
      int k;
      s = 8'h00;
      k = 0;
      while (s !== 8'h80 && k < lim) begin
         rd(`ADDR_STAT_RSEL, s);
         k++;
      end
      chk("stat_ready", s, 8'h80);
      if (s !== 8'h80) finish_test();
   endtask
   task automatic tick(output int k);
      k = 0;
      while (!bitTick && k < 100) begin
         cyc(1);
         k++;
      end
      k = 0;
      do begin
         cyc(1);
         k++;
      end while (!bitTick && k < 100);
   endtask
   function automatic int per(input logic [1:0] q);
      case (q)
         `RATE_500K: return 40;
         `RATE_300K: return 66;
         `RATE_250K: return 80;
         default: return 20;
      endcase
   endfunction
   function automatic logic [7:0] lead(input logic p, input logic [1:0] q);
      if (!p) return 8'h00;
      if (q == `RATE_1M) return `PREERASE_1M;
      return (q == `RATE_500K) ? `PREERASE_500K : 8'h00;
   endfunction

   initial begin
      mclk = 0; arst_n = 0; hostAddr = '0; hostWData = '0; hostWrEn = 0; hostRdEn = 0;
      cmdIdle = 0; cfgLoad = 0; cfgIn = '0; op = 2'h0; pc = 3'h0; n_mismatch = 0;
      samples_checked = 0; cycles = 0;
      void'($urandom(38396));
      dataRdIn = 8'($urandom());
      d = '0;
      d.pollEnable = 1'b1;
      cyc(5);
      chk("reset_hold", ctrlReset, 1'b1);
      arst_n = 1'b1;
      rd(`ADDR_STAT_RSEL, v);
      chk("stat_init", v, 8'h00);
      statReady(25);
      chk("cfg_defaults", cfgOut, d);
      chk("precomp_default", precompSel, 3'h0);
      rd(`ADDR_DATA, v);
      chk("data_read", v, dataRdIn);
      rd(10'h100, v);
      chk("unmapped", v, 8'h00);
      rd(`ADDR_COMPAT, v);
      chk("compat_wo", v, 8'h00);
      // Alternate the two rate ports so each write must override the other.
      for (int i = 0; i < 12; i++) begin
         r = 2'($urandom_range(3, 0));
         if (i[0]) begin
            pc = 3'($urandom_range(7, 0));
            wr(`ADDR_STAT_RSEL, {3'h0, pc, r});
         end else begin
            wr(`ADDR_COMPAT, {6'h00, r});
         end
         cyc(1);
         chk("rate_pins", {rate_out_bit1, rate_out_bit0}, r);
         chk("precomp", precompSel, pc);
         tick(n);
         chk("bit_period", n, per(r));
      end
      cfg = d;
      cfg.perpMode = 1'b1;
      load(cfg);
      for (int k = 0; k < 13; k++) begin
         r = k[1:0];
         if (k == 12) begin
            cfg.perpMode = 1'b0;
            load(cfg);
         end
         wr(`ADDR_COMPAT, {6'h00, r});
         cyc(2);
         chk("gap", id_data_gap, (cfg.perpMode && r == `RATE_1M) ? `IDGAP_PERP : `IDGAP_STD);
         op = (k == 12) ? 2'h1 : 2'(k / 4 + 1);
         n = 0;
         while (!done && n < 5000) begin
            cyc(1);
            n++;
         end
         chk("transfer_done", done, 1'b1);
         if (!done) finish_test();
         cyc(3);
         if (op == 2'h3) chk("read_gate", gateSeen, 1'b0);
         else chk("gate_lead", gateAt, lead(cfg.perpMode, r));
         op = 2'h0;
         cyc(2);
      end
      wr(`ADDR_OUTP, 8'h00); // Motors and selects off before sleeping.
      wr(`ADDR_STAT_RSEL, 8'h41);
      cyc(1);
      chk("clk_gated", ctrlClkEn, 1'b0);
      chk("osc_kept", oscStop, 1'b0);
      wr(`ADDR_COMPAT, 8'h03);
      cyc(1);
      chk("compat_in_lp", {rate_out_bit1, rate_out_bit0}, 2'h3);
      chk("still_low", ctrlClkEn, 1'b0);
      rd(`ADDR_STAT_RSEL, v);
      chk("stat_wake", v, 8'h00);
      statReady(10);
      rd(`ADDR_RSEL_RB, v);
      chk("lp_bit_clear", v[6], 1'b0);
      cfg = d;
      cfg.oscPowerdownCfg = 1'b1;
      cfg.fifoThreshold = 4'hA;
      load(cfg);
      cfg.manualLp = 1'b1;
      load(cfg);
      cyc(1);
      chk("mode_lp", ctrlClkEn, 1'b0);
      chk("osc_stop", oscStop, 1'b1);
      // The external oscillator stays stopped for as long as power-down lasts.
      cyc(10);
      chk("osc_held", oscStop, 1'b1);
      t0 = cycles;
      wr(`ADDR_DATA, 8'h5A);
      rd(`ADDR_STAT_RSEL, v);
      chk("rqm_low", v, 8'h00);
      statReady(20);
      chk("osc_wait", (cycles - t0) >= 10, 1'b1);
      chk("cfg_kept", cfgOut, cfg);
      cfg = d;
      cfg.autoLpEn = 1'b1;
      load(cfg);
      // Two idle entries: auto power-down must repeat without being armed again.
      repeat (2) begin
         cmdIdle = 1'b1;
         n = 0;
         while (ctrlClkEn && n < 200) begin
            cyc(1);
            n++;
         end
         chk("auto_lp", n >= 45 && n <= 60, 1'b1);
         cmdIdle = 1'b0;
         statReady(10);
      end
      cfg = d;
      cfg.lockParams = 1'b1;
      cfg.fifoEnable = 1'b1;
      cfg.fifoThreshold = 4'h5;
      cfg.precompStartTrack = 8'($urandom());
      cfg.fifoWriteSel = 1'b1;
      cfg.fifoReadSel = 1'b1;
      cfg.burstSel = 1'b1;
      cfg.impliedSeek = 1'b1;
      load(cfg);
      wr(`ADDR_STAT_RSEL, 8'h40);
      wr(`ADDR_STAT_RSEL, 8'h80);
      rd(`ADDR_STAT_RSEL, v);
      chk("stat_soft", v, 8'h00);
      statReady(25);
      chk("reset_woke", ctrlClkEn, 1'b1);
      chk("rsel_selfclr", ctrlReset, 1'b0);
      e = cfg;
      e.impliedSeek = 1'b0;
      chk("locked_cfg", cfgOut, e);
      cfg.lockParams = 1'b0;
      load(cfg);
      wr(`ADDR_OUTP, 8'h04);
      cyc(40);
      chk("outp_hold", ctrlReset, 1'b1);
      chk("drive_ctl", driveCtl, 8'h04);
      rd(`ADDR_OUTP, v);
      chk("outp_read", v, 8'h04);
      wr(`ADDR_OUTP, 8'h00);
      statReady(25);
      chk("unlocked_cfg", cfgOut, d);
      finish_test();
   end
endmodule // floppy_rate_power_reset_ctrl_test
